// file: sim/hex_register_responder_test.sv
/* self-checking bench for the hex register responder.
   assumes: design files and hxr_regs.vh on the include path. */
`timescale 1ns/1ns
`default_nettype none
`include "hxr_regs.vh"
`define CHK(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module hex_register_responder_test;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic stall = 1'b0;
  logic [7:0] device_state = 8'h00;
  logic [7:0] rx_data;
  logic [7:0] tx_data;
  logic rx_valid, rx_ready, tx_valid, tx_ready, remote_active, radio_on;
  logic [15:0] effective_limit;
  logic [191:0] frame;
  int frames;
  int bad_count = 0;
  int checked = 0;
  int held;
  localparam logic [63:0] cap_rsp = 64'h500100FF010000;
  logic [63:0] sp [3] = '{64'h1520006400, 64'h1520000003, 64'hF0ED000001};
  logic [15:0] se [3] = '{16'h0064, 16'h01F4, 16'h0100};
  always #5 clock = ~clock;
  hxr_responder #(.TIMEOUT_CYCLES(64'd200)) u_hxr_responder (
    .clock(clock), .reset_n(reset_n), .ce(ce), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .device_state(device_state),
    .effective_limit(effective_limit), .remote_active(remote_active),
    .radio_on(radio_on));
  hxr_host_model u_hxr_host_model (.clock(clock), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .stall(stall),
    .frame(frame), .frames(frames));
  // ----------
  // helpers
  // ----------
  function automatic logic [7:0] hx(input logic [3:0] d);
    return (d < 4'hA) ? 8'h30 + d : 8'h37 + d;
  endfunction
  // frame text from wire-order bytes, last char in the low byte
  function automatic logic [191:0] mk(input logic [3:0] c,
      input logic [63:0] p, input int n);
    logic [191:0] v;
    logic [7:0] s;
    v = {176'h0, 8'h3A, hx(c)};
    s = {4'h0, c};
    for (int i = n - 1; i >= 0; i--) begin
      v = {v[175:0], hx(p[8*i+4+:4]), hx(p[8*i+:4])};
      s = s + p[8*i+:8];
    end
    s = 8'h55 - s;
    return {v[167:0], hx(s[7:4]), hx(s[3:0]), 8'h0A};
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic await(input logic [191:0] exp, input string what);
    int n0;
    int k;
    n0 = frames;
    k = 0;
    while (frames == n0 && k < 600) begin
      @(posedge clock);
      k++;
    end
    #1;
    if (frames == n0) begin
      bad_count++;
      close_out();
    end else begin
      `CHK(what, exp, frame)
    end
  endtask
  task automatic xfer(input logic [191:0] req, input logic [191:0] exp,
      input string what);
    u_hxr_host_model.send(req);
    // a character never taken is a hang
    if (u_hxr_host_model.lost != 0) begin
      bad_count++;
      close_out();
    end else begin
      await(exp, what);
    end
  endtask
  // request answered by an echo of itself
  task automatic echo(input logic [3:0] c, input logic [63:0] p,
      input int n, input string what);
    xfer(mk(c, p, n), mk(c, p, n), what);
  endtask
  // ----------
  // sequence
  // ----------
  initial begin
    repeat (5) @(posedge clock);
    #1 reset_n = 1'b1;
    `CHK("limit", `HXR_RST_MAX_BATT, effective_limit)
    `CHK("remote", 1'b0, remote_active)
    tick(2);
    `CHK("radio", 1'b1, radio_on)
    // caps 0x1FF goes out lsb first
    xfer(mk(4'h7, 64'h500100, 3), mk(4'h7, cap_rsp, 7), "caps");
    for (int b = 0; b < 2; b++) begin
      echo(4'h8, {32'h0, 24'h900000, 8'(b)}, 4, "radio set");
      tick(2);
      `CHK("radio", b[0], radio_on)
    end
    // slow drain up to the async report fills the fifo
    stall = 1'b1;
    echo(4'h8, 64'h0E200005, 4, "mode");
    for (int i = 0; i < 3; i++) begin
      echo(4'h8, sp[i], 5, "set");
      tick(2);
      `CHK("remote", 1'b1, remote_active)
      `CHK("limit", se[i], effective_limit)
    end
    xfer(mk(4'h7, 64'hF0ED00, 3) ^ 192'h100,
      mk(4'h4, 64'hAAAA, 2), "bad sum");
    device_state = 8'h05;
    await(mk(4'hA, 64'h01020005, 4), "async");
    stall = 1'b0;
    tick(220);
    `CHK("remote", 1'b0, remote_active)
    `CHK("limit", 16'h0100, effective_limit)
    // ce low must hold back the report of a state change
    held = frames;
    ce = 1'b0;
    device_state = 8'h03;
    tick(40);
    `CHK("frozen frames", held, frames)
    ce = 1'b1;
    await(mk(4'hA, 64'h01020003, 4), "async resumed");
    close_out();
  end
endmodule // hex_register_responder_test
`default_nettype wire

// file: sim/hxr_host_model.sv
/* host model: sends request frames, drains and collects replies.
   assumes: same clock as the responder; the bench calls send. */
`timescale 1ns/1ns
`default_nettype none
module hxr_host_model (
  // clock
  input wire logic clock,
  // request path
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // reply path
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // control and results
  input wire logic stall,
  output logic [191:0] frame,
  output int frames
);
  logic [191:0] cur;
  logic [1:0] phase;
  int lost;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
    frame = '0;
    frames = 0;
    cur = '0;
    phase = 2'h0;
    lost = 0;
  end
  // slow mode takes one char in four so the fifo fills
  always @(posedge clock) begin
    if (tx_valid && tx_ready) begin
      cur = (tx_data == 8'h3A) ? 192'h3A : {cur[183:0], tx_data};
      if (tx_data == 8'h0A) begin
        frame = cur;
        frames = frames + 1;
      end
    end
    phase = phase + 2'h1;
    #1 tx_ready = !stall || (phase == 2'h0);
  end
  // last char sits in the low byte; held until taken or 500 cycles pass
  task automatic send(input logic [191:0] v);
    int i;
    int n;
    logic r;
    i = 23;
    while (i > 0 && v[8*i+:8] == 8'h00) i--;
    while (i >= 0) begin
      rx_data = v[8*i+:8];
      rx_valid = 1'b1;
      n = 0;
      r = 1'b0;
      while (!r && n < 500) begin
        @(negedge clock);
        r = rx_ready;
        @(posedge clock);
        n++;
      end
      if (!r) lost++;
      #1;
      i--;
    end
    rx_valid = 1'b0;
    // released line shows no stale char
    rx_data = ~rx_data;
  endtask
endmodule // hxr_host_model
`default_nettype wire

// file: sim/hxr_responder_sva.sv
/* port checker for the hex register responder.
   assumes: bound into hxr_responder, one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module hxr_responder_sva #(
  parameter [63:0] TIMEOUT_CYCLES = 64'd200
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  // character links
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  // charger side
  input wire logic [7:0] device_state,
  input wire logic [15:0] effective_limit,
  input wire logic remote_active,
  input wire logic radio_on
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ----------
  // helper state
  // ----------
  logic in_frame;
  logic [31:0] idle;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      in_frame <= 1'b0;
      idle <= 32'h0;
    end else begin
      if (tx_valid && tx_ready && ce) begin
        in_frame <= (tx_data != 8'h0A);
      end
      // saturates so a long quiet spell never wraps
      if (rx_valid && rx_ready && ce) begin
        idle <= 32'h0;
      end else if (idle != 32'hFFFFFFFF) begin
        idle <= idle + 32'h1;
      end
    end
  end
  // ----------
  // properties
  // ----------
  sequence s_stalled;
    tx_valid && !tx_ready;
  endsequence
  sequence s_reply_open;
    $fell(rx_ready);
  endsequence
  a_reset_vals: assert property ($rose(reset_n) |-> !tx_valid && rx_ready
    && !remote_active && !radio_on && effective_limit == 16'h01F4)
    else $error("outputs wrong at reset release");
  a_radio_reset: assert property ($rose(reset_n) |-> ##[1:2] radio_on)
    else $error("radio not enabled after reset");
  a_tx_hold: assert property (s_stalled |=> tx_valid && $stable(tx_data))
    else $error("tx char dropped while stalled");
  a_tx_colon: assert property (tx_valid && !in_frame |-> tx_data == 8'h3A)
    else $error("frame does not open with colon");
  a_tx_hex: assert property (tx_valid && in_frame |-> tx_data inside
    {[8'h30:8'h39], [8'h41:8'h46], 8'h0A})
    else $error("frame char not upper hex or newline");
  a_async_report: assert property ($changed(device_state) |->
    ##[0:300] tx_valid)
    else $error("no report after state change");
  a_reply_bound: assert property (s_reply_open |-> ##[0:6] tx_valid)
    else $error("reply late");
  a_ready_block: assert property (s_reply_open |=> !rx_ready [*3])
    else $error("rx reopened during reply");
  a_remote_lapse: assert property ({32'h0, idle} >= TIMEOUT_CYCLES + 64'd8
    |-> !remote_active)
    else $error("remote limit kept after timeout");
endmodule // hxr_responder_sva
bind hxr_responder hxr_responder_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
  u_hxr_responder_sva (.clock(clock), .reset_n(reset_n), .ce(ce),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .device_state(device_state),
  .effective_limit(effective_limit), .remote_active(remote_active),
  .radio_on(radio_on));
`default_nettype wire

// file: verilog/hxr_fifo.v
/*
 * small flip-flop fifo for the transmit character stream.
 * assumes: one clock, synchronous active-low reset, ce freezes state.
 */
`timescale 1ns/1ns
`default_nettype none

module hxr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire clock,
  input wire reset_n,
  input wire ce,
  // fill side
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  // drain side
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready && ce;
  assign pop = out_valid && out_ready && ce;

  always @(posedge clock) begin
    if (!reset_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

endmodule // hxr_fifo

`default_nettype wire

// file: verilog/hxr_regs.vh
/*
 * register offsets, frame codes, reset values and timing counts of the
 * hex register responder.
 * assumes: included by bare name from the design files of the block.
 */
`ifndef HXR_REGS_VH
`define HXR_REGS_VH

// ----------------------------------------------------------------
// register identifiers
// ----------------------------------------------------------------
`define HXR_REG_RADIO_ENABLE 16'h0090
`define HXR_REG_RADIO_CAPS 16'h0150
`define HXR_REG_DEVICE_STATE 16'h0201
`define HXR_REG_NETWORK_MODE 16'h200E
`define HXR_REG_REMOTE_LIMIT 16'h2015
`define HXR_REG_MAX_BATT 16'hEDF0

// ----------------------------------------------------------------
// value and header field widths in bytes
// ----------------------------------------------------------------
`define HXR_LEN_BYTE 3'h1
`define HXR_LEN_HALF 3'h2
`define HXR_LEN_WORD 3'h4
`define HXR_LEN_HDR 3'h3

// ----------------------------------------------------------------
// capability field
// ----------------------------------------------------------------
`define HXR_CAPS_MSB 8
`define HXR_CAPS_DEFAULT 32'h000001FF

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define HXR_RST_RADIO_ENABLE 8'h01
`define HXR_RST_NETWORK_MODE 8'h00
`define HXR_RST_REMOTE_LIMIT 16'h0000
`define HXR_RST_MAX_BATT 16'h01F4

// ----------------------------------------------------------------
// frame codes
// ----------------------------------------------------------------
`define HXR_CH_START 8'h3A
`define HXR_CH_END 8'h0A
`define HXR_CMD_ERROR 4'h4
`define HXR_CMD_GET 4'h7
`define HXR_CMD_SET 4'h8
`define HXR_CMD_ASYNC 4'hA
`define HXR_FRAME_SUM 8'h55
`define HXR_FRAME_ERR_BYTE 8'hAA
`define HXR_FLAG_OK 8'h00
`define HXR_FLAG_UNKNOWN 8'h01
`define HXR_MAX_RX_BYTES 4'h8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HXR_CLK_HZ 64'd100000000
`define HXR_TIMEOUT_S 64'd60
`define HXR_TIMEOUT_CYCLES (`HXR_TIMEOUT_S * `HXR_CLK_HZ)

`endif

// file: verilog/hxr_responder.v
/*
 * hex register responder: parses ascii-hex get/set frames, answers them,
 * reports device state changes unrequested, and keeps the charge limit.
 * assumes: rx characters come from logic on the same clock; tx characters
 * leave through a 4-deep fifo to a consumer that may stall.
 */
`timescale 1ns/1ns
`default_nettype none
`include "hxr_regs.vh"

module hxr_responder #(
  parameter [63:0] TIMEOUT_CYCLES = `HXR_TIMEOUT_CYCLES,
  parameter [31:0] CAPS = `HXR_CAPS_DEFAULT,
  parameter FIFO_DEPTH = 4
) (
  // clock and reset
  input wire clock,
  input wire reset_n,
  input wire ce,
  // received characters
  input wire [7:0] rx_data,
  input wire rx_valid,
  output wire rx_ready,
  // transmitted characters
  output wire [7:0] tx_data,
  output wire tx_valid,
  input wire tx_ready,
  // charger side
  input wire [7:0] device_state,
  output reg [15:0] effective_limit,
  output reg remote_active,
  output reg radio_on
);

  // ----------------------------------------------------------------
  // parser
  // ----------------------------------------------------------------
  localparam [2:0] P_IDLE = 3'b001;
  localparam [2:0] P_CMD = 3'b010;
  localparam [2:0] P_DATA = 3'b100;

  reg [2:0] p_state;
  reg [3:0] p_cmd;
  reg [3:0] p_hi;
  reg p_half;
  reg p_bad;
  reg [3:0] p_cnt;
  reg [7:0] p_sum;
  reg [7:0] rb [0:7];
  reg f_done;
  reg f_resp;
  reg r_err;
  reg [3:0] r_cmd;
  reg [15:0] r_id;
  reg [7:0] r_flags;
  reg [7:0] radio_enable;
  reg [7:0] network_mode;
  reg [15:0] remote_limit;
  reg [15:0] max_batt;
  reg [63:0] idle_cnt;
  reg [7:0] last_state;
  reg st_chg;
  reg t_busy;
  reg [3:0] t_cmd;
  reg [2:0] t_len;
  reg [55:0] t_bytes;
  reg [7:0] t_chk;
  reg [4:0] t_step;
  wire fifo_in_ready;
  wire rx_take;
  wire [4:0] hv;
  wire [7:0] new_byte;
  wire frame_ok;

  function [4:0] hex_val;
    input [7:0] c;
    begin
      if (c >= 8'h30 && c <= 8'h39)
        hex_val = {1'b1, c[3:0]};
      else if (c >= 8'h41 && c <= 8'h46)
        hex_val = {1'b1, c[3:0] + 4'h9};
      else
        hex_val = 5'h00;
    end
  endfunction

  function [7:0] hex_char;
    input [3:0] n;
    begin
      hex_char = (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    end
  endfunction

  // a response is built while nothing else is in flight; holding rx off
  // avoids a second response buffer
  assign rx_ready = !t_busy && !f_done && !f_resp;
  assign rx_take = rx_valid && rx_ready && ce;
  assign hv = hex_val(rx_data);
  assign new_byte = {p_hi, hv[3:0]};
  assign frame_ok = (p_sum == `HXR_FRAME_SUM) && !p_half && !p_bad &&
    (p_cnt != 4'h0);

  always @(posedge clock) begin
    if (!reset_n) begin
      p_state <= P_IDLE;
      p_cmd <= 4'h0;
      p_hi <= 4'h0;
      p_half <= 1'b0;
      p_bad <= 1'b0;
      p_cnt <= 4'h0;
      p_sum <= 8'h00;
      f_done <= 1'b0;
    end else if (ce) begin
      f_done <= 1'b0;
      if (rx_take) begin
        if (rx_data == `HXR_CH_START) begin
          p_state <= P_CMD;
          p_half <= 1'b0;
          p_bad <= 1'b0;
          p_cnt <= 4'h0;
        end else begin
          case (p_state)
            P_CMD: begin
              p_state <= hv[4] ? P_DATA : P_IDLE;
              p_cmd <= hv[3:0];
              p_sum <= {4'h0, hv[3:0]};
            end
            P_DATA: begin
              if (rx_data == `HXR_CH_END) begin
                p_state <= P_IDLE;
                f_done <= 1'b1;
              end else if (!hv[4]) begin
                p_state <= P_IDLE;
              end else if (!p_half) begin
                p_hi <= hv[3:0];
                p_half <= 1'b1;
              end else begin
                p_half <= 1'b0;
                p_sum <= p_sum + new_byte;
                if (p_cnt == `HXR_MAX_RX_BYTES)
                  p_bad <= 1'b1;
                else begin
                  rb[p_cnt[2:0]] <= new_byte;
                  p_cnt <= p_cnt + 4'h1;
                end
              end
            end
            P_IDLE: p_state <= P_IDLE;
            default: p_state <= P_IDLE;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register file and frame execution
  // ----------------------------------------------------------------
  reg rd_ok;
  reg [2:0] rd_len;
  reg [31:0] rd_val;
  wire [15:0] f_id;
  wire [15:0] f_wval;
  wire is_cmd;

  assign f_id = {rb[1], rb[0]};
  assign f_wval = {rb[4], rb[3]};
  assign is_cmd = (p_cnt >= 4'h4) &&
    (p_cmd == `HXR_CMD_GET || p_cmd == `HXR_CMD_SET);

  always @* begin
    rd_ok = 1'b1;
    rd_len = `HXR_LEN_BYTE;
    rd_val = 32'h00000000;
    case (r_id)
      `HXR_REG_RADIO_ENABLE: rd_val = {24'h000000, radio_enable};
      `HXR_REG_RADIO_CAPS: begin
        rd_len = `HXR_LEN_WORD;
        rd_val = {{(31-`HXR_CAPS_MSB){1'b0}}, CAPS[`HXR_CAPS_MSB:0]};
      end
      `HXR_REG_DEVICE_STATE: rd_val = {24'h000000, device_state};
      `HXR_REG_NETWORK_MODE: rd_val = {24'h000000, network_mode};
      `HXR_REG_REMOTE_LIMIT: begin
        rd_len = `HXR_LEN_HALF;
        rd_val = {16'h0000, remote_limit};
      end
      `HXR_REG_MAX_BATT: begin
        rd_len = `HXR_LEN_HALF;
        rd_val = {16'h0000, max_batt};
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge clock) begin
    if (!reset_n) begin
      f_resp <= 1'b0;
      r_err <= 1'b0;
      r_cmd <= 4'h0;
      r_id <= 16'h0000;
      r_flags <= 8'h00;
      radio_enable <= `HXR_RST_RADIO_ENABLE;
      network_mode <= `HXR_RST_NETWORK_MODE;
      remote_limit <= `HXR_RST_REMOTE_LIMIT;
      max_batt <= `HXR_RST_MAX_BATT;
      remote_active <= 1'b0;
      idle_cnt <= 64'h0;
    end else if (ce) begin
      // a reply waits out an async report loaded in the same cycle
      f_resp <= (f_done && (!frame_ok || is_cmd)) || (f_resp && t_busy);
      if (f_done) begin
        r_err <= !frame_ok;
        r_cmd <= p_cmd;
        r_id <= f_id;
        r_flags <= rb[2];
      end
      // no frames for a minute drops remote control
      if (f_done && frame_ok)
        idle_cnt <= 64'h0;
      else if (remote_active && idle_cnt >= TIMEOUT_CYCLES - 64'h1) begin
        remote_active <= 1'b0;
        idle_cnt <= 64'h0;
      end else if (remote_active)
        idle_cnt <= idle_cnt + 64'h1;
      if (f_done && frame_ok && is_cmd && p_cmd == `HXR_CMD_SET &&
          p_cnt >= 4'h5) begin
        case (f_id)
          `HXR_REG_RADIO_ENABLE: radio_enable <= {7'h00, rb[3][0]};
          `HXR_REG_NETWORK_MODE: network_mode <= rb[3];
          `HXR_REG_REMOTE_LIMIT: begin
            remote_limit <= f_wval;
            remote_active <= 1'b1;
          end
          `HXR_REG_MAX_BATT: max_batt <= f_wval;
          default: max_batt <= max_batt;
        endcase
      end
    end
  end

  always @(posedge clock) begin
    if (!reset_n) begin
      effective_limit <= `HXR_RST_MAX_BATT;
      radio_on <= 1'b0;
    end else if (ce) begin
      if (remote_active && remote_limit < max_batt)
        effective_limit <= remote_limit;
      else
        effective_limit <= max_batt;
      radio_on <= (radio_enable == 8'h01);
    end
  end

  // ----------------------------------------------------------------
  // response and report loading
  // ----------------------------------------------------------------
  reg ld_go;
  reg ld_async;
  reg [3:0] ld_cmd;
  reg [2:0] ld_len;
  reg [55:0] ld_bytes;
  reg [7:0] ld_sum;
  integer i;

  always @* begin
    ld_go = 1'b0;
    ld_async = 1'b0;
    ld_cmd = 4'h0;
    ld_len = 3'h0;
    ld_bytes = 56'h0;
    if (f_resp && !t_busy) begin
      ld_go = 1'b1;
      if (r_err) begin
        ld_cmd = `HXR_CMD_ERROR;
        ld_len = `HXR_LEN_HALF;
        ld_bytes = {40'h0, `HXR_FRAME_ERR_BYTE, `HXR_FRAME_ERR_BYTE};
      end else begin
        ld_cmd = r_cmd;
        ld_len = rd_ok ? `HXR_LEN_HDR + rd_len : `HXR_LEN_HDR;
        ld_bytes = {rd_val, rd_ok ? r_flags : `HXR_FLAG_UNKNOWN, r_id};
      end
    end else if (!t_busy && !f_done && !f_resp && st_chg) begin
      ld_go = 1'b1;
      ld_async = 1'b1;
      ld_cmd = `HXR_CMD_ASYNC;
      ld_len = `HXR_LEN_HDR + `HXR_LEN_BYTE;
      ld_bytes = {24'h0, device_state, `HXR_FLAG_OK,
        `HXR_REG_DEVICE_STATE};
    end
    ld_sum = {4'h0, ld_cmd};
    for (i = 0; i < 7; i = i + 1)
      if (i < ld_len)
        ld_sum = ld_sum + ld_bytes[i*8 +: 8];
  end

  // ----------------------------------------------------------------
  // character serialiser into the fifo
  // ----------------------------------------------------------------
  reg [7:0] t_char;
  wire [4:0] t_last;
  wire [4:0] t_off;
  wire [2:0] t_idx;
  wire [7:0] t_byte;

  assign t_last = {1'b0, t_len, 1'b0} + 5'h4;
  assign t_off = t_step - 5'h2;
  assign t_idx = t_off[3:1];
  assign t_byte = (t_idx == t_len) ? t_chk : t_bytes[t_idx*8 +: 8];

  always @* begin
    if (t_step == 5'h0)
      t_char = `HXR_CH_START;
    else if (t_step == 5'h1)
      t_char = hex_char(t_cmd);
    else if (t_step == t_last)
      t_char = `HXR_CH_END;
    else if (!t_off[0])
      t_char = hex_char(t_byte[7:4]);
    else
      t_char = hex_char(t_byte[3:0]);
  end

  always @(posedge clock) begin
    if (!reset_n) begin
      t_busy <= 1'b0;
      t_cmd <= 4'h0;
      t_len <= 3'h0;
      t_bytes <= 56'h0;
      t_chk <= 8'h00;
      t_step <= 5'h0;
      last_state <= 8'h00;
      st_chg <= 1'b0;
    end else if (ce) begin
      last_state <= device_state;
      // a change in the load cycle is kept for the next report
      if (device_state != last_state)
        st_chg <= 1'b1;
      else if (ld_async)
        st_chg <= 1'b0;
      if (ld_go) begin
        t_busy <= 1'b1;
        t_cmd <= ld_cmd;
        t_len <= ld_len;
        t_bytes <= ld_bytes;
        t_chk <= `HXR_FRAME_SUM - ld_sum;
        t_step <= 5'h0;
      end else if (t_busy && fifo_in_ready) begin
        t_step <= t_step + 5'h1;
        if (t_step == t_last)
          t_busy <= 1'b0;
      end
    end
  end

  hxr_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) u_tx_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .in_data(t_char),
    .in_valid(t_busy),
    .in_ready(fifo_in_ready),
    .out_data(tx_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

endmodule // hxr_responder

`default_nettype wire
